// ---- ufc_pkg.sv ----
// shared constants, field layouts and carrier types for the serial channel control block
package ufc_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h04;
  localparam logic [7:0] OFS_ISW = 8'h08;
  localparam logic [7:0] OFS_LFC = 8'h0c;
  localparam logic [7:0] OFS_MOC = 8'h10;
  localparam logic [7:0] OFS_LSTAT = 8'h14;
  localparam logic [7:0] OFS_MSTAT = 8'h18;

  // fifo_control field positions
  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RESET = 1;
  localparam int FC_TX_RESET = 2;
  localparam int FC_DMA = 3;
  localparam int FC_TRIG_LSB = 6;

  // reset values
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] MOC_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // receive trigger levels, selected by a two-bit code
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0e;

  // bit timing in oversample ticks
  localparam logic [5:0] TICKS_PER_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF_BIT = 6'h08;
  localparam logic [5:0] TICKS_STOP_HALF3 = 6'h18;
  localparam logic [5:0] TICKS_STOP_TWO = 6'h20;
  localparam logic [5:0] TICKS_IR_PULSE = 6'h03;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // interrupt status codes
  localparam logic [3:0] ISW_NONE = 4'h1;
  localparam logic [3:0] ISW_RX_DATA = 4'h4;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic force_par;
    logic even_par;
    logic par_en;
    logic stop_sel;
    logic [1:0] wlen;
  } ufc_line_format_type;

  typedef struct packed {
    logic prescale;
    logic infrared;
    logic resume_any;
    logic loopback;
    logic out2;
    logic out1;
    logic rts;
    logic dtr;
  } ufc_modem_ctrl_type;

  typedef struct packed {
    logic frame_err;
    logic par_err;
    logic [7:0] data;
  } ufc_rx_entry_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP = 3'b100
  } ufc_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP = 3'b100
  } ufc_rx_state_type;

endpackage : ufc_pkg

// ---- ufc_channel.sv ----
// one serial channel: ahb-lite registers, fifos, line framing and modem control outputs
//
// Contract
// [R1] Software sets fifo enable in every fifo_control write, else other bits ignored.
// [R2] Receive reset bit clears receive fifo pointers and count only, self-clearing.
// [R3] Transmit reset bit clears transmit fifo pointers and count only, self-clearing.
// [R4] Transfer-mode bit selects normal or dma behaviour of the request pins.
// [R5] Receive trigger code 00/01/10/11 gives 1/4/8/14; reaching it raises interrupt.
// [R6] Word length code 00/01/10/11 gives 5/6/7/8 data bits, both directions.
// [R7] Stop select gives one stop bit, or 1.5 (five bits) / 2 stop bits.
// [R8] Parity enable adds a transmitted parity bit and receive parity checking.
// [R9] Even-select zero gives odd parity, one gives even, for send and check.
// [R10] Forced parity sends and expects one when even-select zero, else zero.
// [R11] Break bit holds serial output at space until software clears it; loopback or infrared park it high instead.
// [R12] Divisor-access bit steers the low addresses to the divisor latch.
// [R13] Terminal-ready bit drives its pin inverted, high by default.
// [R14] Request-to-send bit drives its pin inverted, high by default.
// [R15] Spare output one has no pin; in loopback it feeds ring status.
// [R16] Output-two zero tristates interrupt pin, drives spare two high; one reverses.
// [R17] Loopback bit routes the channel internally; clear gives normal operation.
// [R18] Resume-any lets any received character restart a halted transmitter.
// [R19] Infrared bit routes data through encoder/decoder; infrared output idles low.
// [R20] Prescaler bit divides the baud generator clock by four.
// [R21] Interrupt status top two bits read one only while fifos are enabled.
// [R22] Both divisor registers are reachable only with divisor-access set.
// [R23] Character framing: low start, data lsb first, optional parity, high stops.
module ufc_channel
  import ufc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial line
  input wire logic serial_in,
  output logic serial_out,
  input wire logic ir_in,
  output logic ir_out,
  // modem
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ring_indicator_in_n,
  input wire logic cd_n,
  output logic dtr_n,
  output logic rts_n,
  output logic spare_output_two_n,
  // interrupt pin with enable
  output logic irq_out,
  output logic irq_oe,
  // request pins
  output logic tx_request_pin_n,
  output logic rx_request_pin_n,
  // flow control hooks from the surrounding logic
  input wire logic flow_halt,
  input wire logic flow_resume,
  input wire logic flow_char_match
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CAP_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CAP_ONE = (AW+1)'(1);

  ufc_line_format_type lfc_reg;
  ufc_modem_ctrl_type moc_reg;
  logic fifo_en_reg;
  logic dma_mode_reg;
  logic [1:0] trig_sel_reg;
  logic [15:0] divisor_reg;

  // bus phases
  logic take;
  logic wr_pend_reg;
  logic rd_wait_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic wr_data;
  logic wr_fcr;
  logic rd_data_pop;
  logic rd_lstat;

  assign take = hsel && htrans[1] && hready;
  assign hreadyout = ~rd_wait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_wait_reg <= take && !hwrite;
      if (take) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  assign wr_data = wr_pend_reg && (addr_reg == OFS_DATA) && !lfc_reg.dlab;
  assign wr_fcr = wr_pend_reg && (addr_reg == OFS_ISW);
  assign rd_data_pop = rd_wait_reg && (addr_reg == OFS_DATA) && !lfc_reg.dlab;
  assign rd_lstat = rd_wait_reg && (addr_reg == OFS_LSTAT);

  // control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfc_reg <= LFC_RESET;
      moc_reg <= MOC_RESET;
      divisor_reg <= DIV_RESET;
    end else if (wr_pend_reg) begin
      if (addr_reg == OFS_LFC) begin
        lfc_reg <= hwdata[7:0];
      end else if (addr_reg == OFS_MOC) begin
        moc_reg <= hwdata[7:0];
      end else if (addr_reg == OFS_DATA && lfc_reg.dlab) begin
        divisor_reg[7:0] <= hwdata[7:0]; // R12
      end else if (addr_reg == OFS_DIV_HIGH && lfc_reg.dlab) begin
        divisor_reg[15:8] <= hwdata[7:0]; // R22
      end
    end
  end

  // fifo_control: write-only, fields taken only with the enable bit set
  logic fifo_en_rise;
  logic rx_clear;
  logic tx_clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_en_reg <= 1'b0;
      dma_mode_reg <= 1'b0;
      trig_sel_reg <= 2'b00;
    end else if (wr_fcr) begin
      fifo_en_reg <= hwdata[FC_ENABLE]; // R1
      if (hwdata[FC_ENABLE]) begin
        dma_mode_reg <= hwdata[FC_DMA]; // R4
        trig_sel_reg <= hwdata[FC_TRIG_LSB+:2]; // R5
      end
    end
  end

  // a mode change of the fifos empties them so the capacity stays consistent
  assign fifo_en_rise = wr_fcr && (hwdata[FC_ENABLE] != fifo_en_reg);
  assign rx_clear = fifo_en_rise || (wr_fcr && hwdata[FC_ENABLE] && hwdata[FC_RX_RESET]); // R2
  assign tx_clear = fifo_en_rise || (wr_fcr && hwdata[FC_ENABLE] && hwdata[FC_TX_RESET]); // R3

  logic [AW:0] cap;
  logic [4:0] trig_level;
  assign cap = fifo_en_reg ? CAP_FULL : CAP_ONE;

  always_comb begin
    case (trig_sel_reg)
      2'b00: trig_level = TRIG_LVL0;
      2'b01: trig_level = TRIG_LVL1;
      2'b10: trig_level = TRIG_LVL2;
      default: trig_level = TRIG_LVL3;
    endcase
    if (!fifo_en_reg) begin
      trig_level = TRIG_LVL0;
    end
  end

  // baud tick: optional divide by four, then the 16-bit divisor
  logic [1:0] pre_cnt_reg;
  logic pre_tick;
  logic [15:0] div_cnt_reg;
  logic [15:0] div_last;
  logic tick;

  assign pre_tick = moc_reg.prescale ? (pre_cnt_reg == PRESCALE_LAST) : 1'b1; // R20
  assign div_last = (divisor_reg == 16'h0000) ? 16'h0000 : divisor_reg - 16'h0001;
  assign tick = pre_tick && (div_cnt_reg >= div_last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_reg <= 2'b00;
      div_cnt_reg <= 16'h0000;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 2'b01;
      if (tick) begin
        div_cnt_reg <= 16'h0000;
      end else if (pre_tick) begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
    end
  end

  function automatic logic parity_of(input logic [7:0] d, input ufc_line_format_type f);
    logic [7:0] m;
    m = d & (8'hff >> (2'd3 - f.wlen));
    if (f.force_par) begin
      parity_of = ~f.even_par; // R10
    end else begin
      parity_of = f.even_par ? ^m : ~^m; // R9
    end
  endfunction : parity_of

  logic [5:0] stop_ticks;
  assign stop_ticks = !lfc_reg.stop_sel ? TICKS_PER_BIT :
                      (lfc_reg.wlen == 2'b00) ? TICKS_STOP_HALF3 : TICKS_STOP_TWO; // R7

  // transmit fifo
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_reg;
  logic [AW-1:0] tx_rp_reg;
  logic [AW:0] tx_cnt_reg;
  logic tx_push;
  logic tx_pop;

  assign tx_push = wr_data && (tx_cnt_reg < cap);

  always_ff @(posedge hclk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else if (tx_clear) begin
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_wp_reg <= tx_wp_reg + 1'b1;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 1'b1;
      end
      tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // transmitter; the shift register keeps running through a fifo reset
  ufc_tx_state_type tx_state_reg;
  logic [7:0] tx_shift_reg;
  logic tx_par_reg;
  logic [5:0] tx_tick_reg;
  logic [2:0] tx_bit_reg;
  logic tx_halted_reg;
  logic tx_line;
  logic rx_store_evt;

  assign tx_pop = (tx_state_reg == TX_IDLE) && (tx_cnt_reg != '0) && !tx_halted_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_par_reg <= 1'b0;
      tx_tick_reg <= 6'h00;
      tx_bit_reg <= 3'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_shift_reg <= tx_mem[tx_rp_reg];
            tx_par_reg <= parity_of(tx_mem[tx_rp_reg], lfc_reg); // R8
            tx_tick_reg <= 6'h00;
            tx_state_reg <= TX_START; // R23
          end
        end
        TX_START: begin
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 6'h01;
            if (tx_tick_reg == TICKS_PER_BIT - 6'h01) begin
              tx_tick_reg <= 6'h00;
              tx_bit_reg <= 3'h0;
              tx_state_reg <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 6'h01;
            if (tx_tick_reg == TICKS_PER_BIT - 6'h01) begin
              tx_tick_reg <= 6'h00;
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]}; // R23
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == {1'b0, lfc_reg.wlen} + 3'h4) begin // R6
                tx_state_reg <= lfc_reg.par_en ? TX_PARITY : TX_STOP; // R8
              end
            end
          end
        end
        TX_PARITY: begin
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 6'h01;
            if (tx_tick_reg == TICKS_PER_BIT - 6'h01) begin
              tx_tick_reg <= 6'h00;
              tx_state_reg <= TX_STOP;
            end
          end
        end
        default: begin
          if (tick) begin
            tx_tick_reg <= tx_tick_reg + 6'h01;
            if (tx_tick_reg == stop_ticks - 6'h01) begin // R7
              tx_tick_reg <= 6'h00;
              tx_state_reg <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // halted by flow control; a set from the halt input wins over a resume
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_halted_reg <= 1'b0;
    end else if (flow_halt) begin
      tx_halted_reg <= 1'b1;
    end else if (flow_resume || (rx_store_evt && moc_reg.resume_any)) begin
      tx_halted_reg <= 1'b0; // R18
    end
  end

  always_comb begin
    case (tx_state_reg)
      TX_START: tx_line = 1'b0;
      TX_DATA: tx_line = tx_shift_reg[0];
      TX_PARITY: tx_line = tx_par_reg;
      default: tx_line = 1'b1;
    endcase
    if (lfc_reg.brk) begin
      tx_line = 1'b0; // R11
    end
  end

  // pin outputs; loopback parks every line in its idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out <= 1'b1;
      ir_out <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      spare_output_two_n <= 1'b1;
    end else begin
      serial_out <= moc_reg.loopback || moc_reg.infrared || tx_line; // R17 R19
      ir_out <= moc_reg.infrared && !moc_reg.loopback && !tx_line
                && (tx_tick_reg < TICKS_IR_PULSE); // R19
      dtr_n <= moc_reg.loopback || !moc_reg.dtr; // R13
      rts_n <= moc_reg.loopback || !moc_reg.rts; // R14
      spare_output_two_n <= moc_reg.loopback || !moc_reg.out2; // R16
    end
  end

  // pin synchronisers
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 6'h2f;
      sync2_reg <= 6'h2f;
    end else begin
      sync1_reg <= {serial_in, ir_in, cts_n, dsr_n, ring_indicator_in_n, cd_n};
      sync2_reg <= sync1_reg;
    end
  end

  // infrared decoder stretches each received pulse into one space bit
  logic [5:0] ir_hold_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_hold_reg <= 6'h00;
    end else if (sync2_reg[4]) begin
      ir_hold_reg <= TICKS_PER_BIT;
    end else if (tick && ir_hold_reg != 6'h00) begin
      ir_hold_reg <= ir_hold_reg - 6'h01;
    end
  end

  logic rx_line;
  assign rx_line = moc_reg.loopback ? tx_line :
                   moc_reg.infrared ? (ir_hold_reg == 6'h00) : sync2_reg[5]; // R17 R19

  // receiver
  ufc_rx_state_type rx_state_reg;
  logic [7:0] rx_shift_reg;
  logic [5:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic rx_par_err_reg;
  logic rx_mid;
  logic [7:0] rx_word;
  logic rx_push;
  logic overrun_reg;

  assign rx_mid = tick && (rx_tick_reg == TICKS_PER_BIT - 6'h01);
  assign rx_word = rx_shift_reg >> (2'd3 - lfc_reg.wlen); // R6
  assign rx_store_evt = (rx_state_reg == RX_STOP) && rx_mid;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_tick_reg <= 6'h00;
      rx_bit_reg <= 3'h0;
      rx_par_err_reg <= 1'b0;
    end else begin
      if (tick) begin
        rx_tick_reg <= rx_mid ? 6'h00 : rx_tick_reg + 6'h01;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          rx_tick_reg <= 6'h00;
          rx_par_err_reg <= 1'b0;
          if (!rx_line) begin
            rx_state_reg <= RX_START; // R23
          end
        end
        RX_START: begin
          if (tick && rx_tick_reg == TICKS_HALF_BIT - 6'h01) begin
            rx_tick_reg <= 6'h00;
            rx_bit_reg <= 3'h0;
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]}; // R23
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == {1'b0, lfc_reg.wlen} + 3'h4) begin
              rx_state_reg <= lfc_reg.par_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_mid) begin
            rx_par_err_reg <= rx_line != parity_of(rx_word, lfc_reg); // R8 R9 R10
            rx_state_reg <= RX_STOP;
          end
        end
        default: begin
          if (rx_mid) begin
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // receive fifo; flow characters under software flow control are not stored
  ufc_rx_entry_type rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_reg;
  logic [AW-1:0] rx_rp_reg;
  logic [AW:0] rx_cnt_reg;
  logic rx_pop;
  ufc_rx_entry_type rx_head;

  assign rx_push = rx_store_evt && !flow_char_match && (rx_cnt_reg < cap); // R18
  assign rx_pop = rd_data_pop && (rx_cnt_reg != '0);
  assign rx_head = (rx_cnt_reg != '0) ? rx_mem[rx_rp_reg] : '0;

  always_ff @(posedge hclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= '{frame_err: !rx_line, par_err: rx_par_err_reg, data: rx_word};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (rx_clear) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rx_wp_reg <= rx_wp_reg + 1'b1;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 1'b1;
      end
      rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  // overrun: a new overrun wins over the clearing status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_reg <= 1'b0;
    end else if (rx_store_evt && !flow_char_match && !(rx_cnt_reg < cap)) begin
      overrun_reg <= 1'b1;
    end else if (rd_lstat) begin
      overrun_reg <= 1'b0;
    end
  end

  // status, interrupt pin and request pins
  logic rx_trig;
  logic [7:0] isw;
  logic [7:0] lstat;
  logic [7:0] mstat;

  assign rx_trig = 32'(rx_cnt_reg) >= 32'(trig_level); // R5
  assign isw = {fifo_en_reg, fifo_en_reg, 2'b00, rx_trig ? ISW_RX_DATA : ISW_NONE}; // R21
  assign lstat = {1'b0, (tx_cnt_reg == '0) && (tx_state_reg == TX_IDLE), tx_cnt_reg == '0,
                  1'b0, rx_head.frame_err, rx_head.par_err, overrun_reg, rx_cnt_reg != '0};
  assign mstat = moc_reg.loopback ?
                 {moc_reg.out2, moc_reg.out1, moc_reg.dtr, moc_reg.rts, 4'h0} : // R15
                 {~sync2_reg[0], ~sync2_reg[1], ~sync2_reg[2], ~sync2_reg[3], 4'h0};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
      tx_request_pin_n <= 1'b1;
      rx_request_pin_n <= 1'b1;
    end else begin
      irq_out <= rx_trig; // R5
      irq_oe <= moc_reg.out2; // R16
      if (dma_mode_reg) begin
        rx_request_pin_n <= !rx_trig; // R4
        tx_request_pin_n <= !(tx_cnt_reg < cap);
      end else begin
        rx_request_pin_n <= rx_cnt_reg == '0; // R4
        tx_request_pin_n <= tx_cnt_reg != '0;
      end
    end
  end

  // read data latched in the single wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_wait_reg) begin
      hrdata_reg <= 32'h00000000;
      if (addr_reg == OFS_DATA) begin
        hrdata_reg[7:0] <= lfc_reg.dlab ? divisor_reg[7:0] : rx_head.data; // R12
      end else if (addr_reg == OFS_DIV_HIGH && lfc_reg.dlab) begin
        hrdata_reg[7:0] <= divisor_reg[15:8]; // R22
      end else if (addr_reg == OFS_ISW) begin
        hrdata_reg[7:0] <= isw;
      end else if (addr_reg == OFS_LFC) begin
        hrdata_reg[7:0] <= lfc_reg;
      end else if (addr_reg == OFS_MOC) begin
        hrdata_reg[7:0] <= moc_reg;
      end else if (addr_reg == OFS_LSTAT) begin
        hrdata_reg[7:0] <= lstat;
      end else if (addr_reg == OFS_MSTAT) begin
        hrdata_reg[7:0] <= mstat;
      end
    end
  end

endmodule : ufc_channel

// ---- ufc_properties.sv ----
// concurrent checks on the channel's bus and control pins
module ufc_properties
  import ufc_pkg::*;
(
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // pins
  input wire logic serial_out,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic spare_output_two_n,
  input wire logic irq_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take, wr_reg, rd_reg, fen_reg, done, calm;
  logic [7:0] a_reg, lfc_reg, moc_reg;
  logic [1:0] age_reg;
  assign take = hsel & htrans[1] & hreadyout;
  assign done = rd_reg & hreadyout;
  assign calm = age_reg == 2'h3;
  // pins judged once the registered outputs settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_reg, rd_reg, fen_reg, a_reg, lfc_reg, moc_reg, age_reg} <= {27'h0, 2'h3};
    end else begin
      if (hreadyout) begin
        wr_reg <= take & hwrite;
        rd_reg <= take & !hwrite;
        a_reg <= haddr[7:0];
      end
      age_reg <= wr_reg ? 2'h0 : age_reg + 2'(!calm);
      if (wr_reg && a_reg == OFS_LFC) lfc_reg <= hwdata[7:0];
      if (wr_reg && a_reg == OFS_MOC) moc_reg <= hwdata[7:0];
      if (wr_reg && a_reg == OFS_ISW) fen_reg <= hwdata[0];
    end
  end
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_dtr_level: assert property (calm |-> dtr_n == (moc_reg[4] | !moc_reg[0]))
    else $error("terminal ready pin wrong");
  chk_rts_level: assert property (calm |-> rts_n == (moc_reg[4] | !moc_reg[1]))
    else $error("request to send pin wrong");
  chk_irq_enable: assert property (calm |-> irq_oe == moc_reg[3] &&
    spare_output_two_n == (moc_reg[4] | !moc_reg[3])) else $error("output two wrong");
  chk_break_space: assert property (calm && lfc_reg[6] && moc_reg[6:4] == 3'h0
    |-> !serial_out) else $error("break not at space");
  chk_line_parked: assert property (calm && (moc_reg[4] | moc_reg[6]) && !lfc_reg[6]
    |-> serial_out) else $error("serial out not parked high");
  chk_isw_top: assert property (done && a_reg == OFS_ISW |-> hrdata[7:6] == {2{fen_reg}})
    else $error("status top bits wrong");
  chk_div_gate: assert property (done && a_reg == OFS_DIV_HIGH && !lfc_reg[7] |-> hrdata == 0)
    else $error("divisor readable while gated");
  chk_lfc_back: assert property (done && a_reg == OFS_LFC |-> hrdata == {24'h0, lfc_reg})
    else $error("line format readback wrong");
endmodule : ufc_properties

// ---- ufc_remote.sv ----
// remote serial device: frames characters both ways at 16 clocks a bit
module ufc_remote (
  // line
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;
  task automatic send(input logic [7:0] d, input int nb);
    line_out <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (16) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (16) @(posedge clk);
  endtask : send
  // twelve bit centres after the start edge
  task automatic grab(output logic [11:0] bits, output bit ok);
    int n = 0;
    while (line_in !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 400);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      bits[i] = line_in;
      repeat (16) @(posedge clk);
    end
  endtask : grab
endmodule : ufc_remote

// ---- testbench.sv ----
// self-checking bench for the serial channel control block
module testbench
  import ufc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, serial_in, serial_out;
  logic ir_out, dtr_n, rts_n, sp2_n, irq_out, irq_oe, txp_n, rxp_n;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 23;
  logic [1:0] htrans = 0;
  logic [3:0] mdm = 4'hf;
  logic [7:0] fmt [8] = '{8'h00, 8'h01, 8'h0b, 8'h1a, 8'h2b, 8'h3b, 8'h07, 8'h04};
  logic [7:0] rxq [$];
  int err_total = 0;
  int checked = 0;
  always #4 hclk = ~hclk;
  ufc_channel dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .serial_in, .serial_out, .ir_in(1'b0),
    .ir_out, .cts_n(mdm[0]), .dsr_n(mdm[1]), .ring_indicator_in_n(mdm[2]), .cd_n(mdm[3]),
    .dtr_n, .rts_n, .spare_output_two_n(sp2_n), .irq_out, .irq_oe, .tx_request_pin_n(txp_n),
    .rx_request_pin_n(rxp_n), .flow_halt(1'b0), .flow_resume(1'b0), .flow_char_match(1'b0));
  ufc_remote remote_u (.clk(hclk), .line_in(serial_out), .line_out(serial_in));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdy();
    for (int n = 0; n < 20; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    err_total++;
    end_of_test();
  endtask : rdy
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rdy();
    r = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr
  task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 8'h00, r);
    chk(nm, e, r);
  endtask : rc
  initial begin
    logic [31:0] v;
    logic [11:0] bits, e;
    bit ok;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc("lfc reset", OFS_LFC, 0);
    rc("moc reset", OFS_MOC, 0);
    rc("isw reset", OFS_ISW, 32'h01);
    rc("div gated", OFS_DIV_HIGH, 0);
    rc("unmapped", 8'h1c, 0);
    wr(OFS_LFC, 8'h80);
    wr(OFS_DIV_HIGH, 8'h5a);
    rc("div open", OFS_DIV_HIGH, 32'h5a);
    wr(OFS_DIV_HIGH, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = rnd() & (32'hff >> (3 - fmt[i][1:0]));
      e = {3'h7, v[7:0], 1'b0} | (12'hfff << (6 + fmt[i][1:0]));
      if (fmt[i][3]) e[6 + fmt[i][1:0]] = fmt[i][5] ? !fmt[i][4] : (^v ^ !fmt[i][4]);
      wr(OFS_LFC, fmt[i]);
      wr(OFS_DATA, v[7:0]);
      remote_u.grab(bits, ok);
      chk("frame", e, ok ? bits : 12'h000);
    end
    wr(OFS_LFC, 8'h43);
    repeat (8) @(posedge hclk);
    chk("break", 0, serial_out);
    wr(OFS_LFC, 8'h03);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      mdm <= v[11:8];
      wr(OFS_MOC, v[7:0]);
      repeat (4) @(posedge hclk);
      chk("dtr pin", v[4] | !v[0], dtr_n);
      chk("rts pin", v[4] | !v[1], rts_n);
      chk("irq enable", v[3], irq_oe);
      chk("spare two", v[4] | !v[3], sp2_n);
      rc("moc back", OFS_MOC, v[7:0]);
      e = v[4] ? {v[3], v[2], v[0], v[1]} : ~v[11:8];
      xfer(OFS_MSTAT, 1'b0, 8'h00, v);
      chk("modem in", e[3:0], v[7:4]);
    end
    wr(OFS_MOC, 8'h00);
    wr(OFS_ISW, 8'h41);
    rc("isw on", OFS_ISW, 32'hc1);
    chk("tx pin normal", 0, txp_n);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      rxq.push_back(v[7:0]);
      remote_u.send(v[7:0], 8);
      chk("trigger", i == 3, irq_out);
    end
    rc("rx data", OFS_DATA, rxq.pop_front());
    repeat (2) @(posedge hclk);
    chk("below trigger", 0, irq_out);
    chk("rx pin normal", 0, rxp_n);
    wr(OFS_ISW, 8'h49);
    repeat (2) @(posedge hclk);
    chk("rx pin dma", 1, rxp_n);
    chk("tx pin dma", 0, txp_n);
    wr(OFS_ISW, 8'h4b);
    repeat (2) @(posedge hclk);
    rc("rx cleared", OFS_LSTAT, 32'h60);
    wr(OFS_ISW, 8'hc0);
    rc("isw off", OFS_ISW, 32'h01);
    end_of_test();
  end
  initial begin
    repeat (90000) @(posedge hclk);
    err_total++;
    end_of_test();
  end
endmodule : testbench
bind ufc_channel ufc_properties chk_u (.*);
